// File: pkg/game_seq_pkg.sv
package game_seq_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RESET_DELAY_MS  = 3000;
  localparam int unsigned GAME_OVER_MS    = 5000;
  localparam int unsigned DEBOUNCE_US     = 10000;
  localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned GAME_OVER_CYC   = GAME_OVER_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  localparam int SEG_W    = 4;
  localparam int BAT_W    = 8;
  localparam int SCORE_W  = 7;
  localparam int CREDIT_W = 8;
  localparam int HIT_W    = 3;
  localparam int SEL_W    = 3;
  localparam int TMR_W    = 32;
  localparam int IN_RX    = 0;
  localparam int IN_COIN  = 1;
  localparam int N_IN     = 2;

  localparam logic [SEG_W-1:0]    DIV_LAST   = 4'hf;
  localparam logic [SEG_W-1:0]    SEG_LAST   = 4'hf;
  localparam logic [BAT_W-1:0]    BAT_LAST   = 8'hff;
  localparam logic [SCORE_W-1:0]  SCORE_STEP = 7'h0a;
  localparam logic [SEL_W-1:0]    SEL_MIN    = 3'h1;
  localparam logic [CREDIT_W-1:0] CREDIT_MAX = 8'hff;

  typedef enum logic [1:0] {PH_IDLE, PH_PITCH, PH_RESET_DLY, PH_GAME_OVER} phase_t;

  typedef struct packed {
    logic [N_IN-1:0]            sync1;
    logic [N_IN-1:0]            sync2;
    logic [N_IN-1:0]            stable;
    logic [N_IN-1:0][TMR_W-1:0] db_cnt;
    phase_t                     phase;
    logic [SEG_W-1:0]           div_cnt;
    logic                       pitch_on;
    logic [SEG_W-1:0]           ball_seg;
    logic                       swing_req;
    logic                       bat_on;
    logic [BAT_W-1:0]           bat_cnt;
    logic                       hit_done;
    logic                       hit_p;
    logic                       ret_p;
    logic [TMR_W-1:0]           tmr;
    logic                       second_up;
    logic [SCORE_W-1:0]         score_first;
    logic [SCORE_W-1:0]         score_second;
    logic                       end_prev;
    logic [CREDIT_W-1:0]        credits;
  } state_t;

endpackage

// File: rtl/pitch_bat_game_sequencer.sv
module pitch_bat_game_sequencer
  import game_seq_pkg::*;
#(
  parameter int unsigned RD_CYC = game_seq_pkg::RESET_DELAY_CYC, // reset delay length
  parameter int unsigned GO_CYC = game_seq_pkg::GAME_OVER_CYC,   // game-over length
  parameter int unsigned DB_CYC = game_seq_pkg::DEBOUNCE_CYC     // debounce length
)(
  input  wire logic                               clk,            // master clock
  input  wire logic                               rst_n,          // async reset
  input  wire logic                               clk_en,         // freezes all state when low
  input  wire logic                               rx_n_pin,       // receiver, low while keyed
  input  wire logic                               coin_n_pin,     // coin contact, low when closed
  input  wire logic [game_seq_pkg::SEL_W-1:0]     score_sel,      // end score in tens
  input  wire logic [game_seq_pkg::HIT_W-1:0]     hit_value,      // points for a hit
  output logic      [game_seq_pkg::SEG_W-1:0]     ball_seg,       // ball animation segment
  output logic      [game_seq_pkg::SEG_W-1:0]     bat_seg,        // bat swing segment
  output logic                                    pitch_gate_en,  // pitch flip-flop output
  output logic                                    pitch_done,     // its complement
  output logic                                    swing_active,   // bat gate open
  output logic                                    reset_delay,    // post-pitch delay pulse
  output logic                                    ball_return,    // one-cycle return pulse
  output logic                                    hit_n,          // one-cycle hit pulse
  output logic                                    first_batter,   // first batter is up
  output logic      [game_seq_pkg::SCORE_W-1:0]   score_first,    // first batter score
  output logic      [game_seq_pkg::SCORE_W-1:0]   score_second,   // second batter score
  output logic                                    game_over,      // game-over pulse
  output logic      [game_seq_pkg::CREDIT_W-1:0]  credits         // credited games
);
  import game_seq_pkg::*;

  state_t               s_r;
  state_t               s_nxt;
  logic [N_IN-1:0]      rise;
  logic                 step;
  logic                 coincide;
  logic                 end_now;
  logic                 go_start;
  logic                 credit_inc;
  logic                 credit_dec;
  logic [SEL_W-1:0]     sel;
  logic [SCORE_W-1:0]   threshold;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.hit_p = 1'b0;
    s_nxt.ret_p = 1'b0;
    // both inputs are active low at the pin; stored active high
    s_nxt.sync1 = {~coin_n_pin, ~rx_n_pin};
    s_nxt.sync2 = s_r.sync1;
    rise = '0;
    for (int i = 0; i < N_IN; i++)
    begin
      if (s_r.sync2[i] == s_r.stable[i])
        s_nxt.db_cnt[i] = '0;
      else if (s_r.db_cnt[i] >= TMR_W'(DB_CYC - 1))
      begin
        s_nxt.db_cnt[i] = '0;
        s_nxt.stable[i] = s_r.sync2[i];
        rise[i]         = s_r.sync2[i];
      end
      else
        s_nxt.db_cnt[i] = s_r.db_cnt[i] + TMR_W'(1);
    end

    s_nxt.div_cnt = s_r.div_cnt + SEG_W'(1);
    step = s_r.pitch_on && (s_r.div_cnt == DIV_LAST);

    if (s_r.bat_on)
    begin
      if (s_r.bat_cnt == BAT_LAST)
        s_nxt.bat_on = 1'b0;
      else
        s_nxt.bat_cnt = s_r.bat_cnt + BAT_W'(1);
    end

    // only the upper half of the trajectory can be hit
    coincide = (s_r.phase == PH_PITCH) && s_r.bat_on && !s_r.hit_done
               && s_r.ball_seg[SEG_W-1]
               && (s_r.ball_seg == s_r.bat_cnt[BAT_W-1 -: SEG_W]);
    if (coincide)
    begin
      s_nxt.hit_p    = 1'b1;
      s_nxt.hit_done = 1'b1;
      if (s_r.second_up)
        s_nxt.score_second = s_r.score_second + SCORE_W'(hit_value);
      else
        s_nxt.score_first = s_r.score_first + SCORE_W'(hit_value);
    end

    case (s_r.phase)
      PH_IDLE:
      begin
        if (rise[IN_RX] && (s_r.credits != '0))
        begin
          s_nxt.phase    = PH_PITCH;
          s_nxt.pitch_on = 1'b1;
          s_nxt.ball_seg = '0;
        end
      end
      PH_PITCH:
      begin
        if (rise[IN_RX] && !s_r.swing_req)
        begin
          s_nxt.swing_req = 1'b1;
          s_nxt.bat_on    = 1'b1;
          s_nxt.bat_cnt   = '0;
        end
        if (step)
        begin
          if (s_r.ball_seg == SEG_LAST)
          begin
            s_nxt.pitch_on = 1'b0;
            s_nxt.phase    = PH_RESET_DLY;
            s_nxt.tmr      = '0;
          end
          else
            s_nxt.ball_seg = s_r.ball_seg + SEG_W'(1);
        end
      end
      PH_RESET_DLY:
      begin
        if (s_r.tmr >= TMR_W'(RD_CYC - 1))
        begin
          s_nxt.phase     = PH_IDLE;
          s_nxt.ret_p     = 1'b1;
          s_nxt.ball_seg  = '0;
          s_nxt.swing_req = 1'b0;
          s_nxt.hit_done  = 1'b0;
          s_nxt.second_up = ~s_r.second_up;
        end
        else
          s_nxt.tmr = s_r.tmr + TMR_W'(1);
      end
      PH_GAME_OVER:
      begin
        if (s_r.tmr >= TMR_W'(GO_CYC - 1))
        begin
          s_nxt.phase        = PH_IDLE;
          s_nxt.score_first  = '0;
          s_nxt.score_second = '0;
          s_nxt.second_up    = 1'b0;
          s_nxt.ball_seg     = '0;
          s_nxt.swing_req    = 1'b0;
          s_nxt.hit_done     = 1'b0;
        end
        else
          s_nxt.tmr = s_r.tmr + TMR_W'(1);
      end
      default:
        s_nxt.phase = PH_IDLE;
    endcase

    // a zero selection is read as the lowest step so the game does not end at zero points
    sel = (score_sel < SEL_MIN) ? SEL_MIN : score_sel;
    threshold = SCORE_W'(sel) * SCORE_STEP;
    end_now = ((s_r.score_first >= threshold) || (s_r.score_second >= threshold))
              && !s_r.second_up;
    s_nxt.end_prev = end_now;
    go_start = end_now && !s_r.end_prev && (s_r.phase != PH_GAME_OVER);
    if (go_start)
    begin
      s_nxt.phase    = PH_GAME_OVER;
      s_nxt.tmr      = '0;
      s_nxt.pitch_on = 1'b0;
      s_nxt.bat_on   = 1'b0;
    end

    // below CREDIT_MAX, a coin and a game-over in one cycle cancel rather than lose either
    credit_inc = rise[IN_COIN] && (s_r.credits != CREDIT_MAX);
    credit_dec = go_start && (s_r.credits != '0);
    s_nxt.credits = s_r.credits + CREDIT_W'(credit_inc) - CREDIT_W'(credit_dec);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign ball_seg      = s_r.ball_seg;
  assign bat_seg       = s_r.bat_cnt[BAT_W-1 -: SEG_W];
  assign pitch_gate_en = s_r.pitch_on;
  assign pitch_done    = ~s_r.pitch_on;
  assign swing_active  = s_r.bat_on;
  assign reset_delay   = (s_r.phase == PH_RESET_DLY);
  assign ball_return   = s_r.ret_p;
  assign hit_n         = ~s_r.hit_p;
  assign first_batter  = ~s_r.second_up;
  assign score_first   = s_r.score_first;
  assign score_second  = s_r.score_second;
  assign game_over     = (s_r.phase == PH_GAME_OVER);
  assign credits       = s_r.credits;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence pitch_leaves;
    $fell(pitch_gate_en) ##0 !game_over;
  endsequence
  sequence delay_runs;
    reset_delay [*2];
  endsequence

  chk_pitch_end_delay: assert property (pitch_leaves |-> pitch_done ##0 delay_runs)
    else $error("pitch end did not start reset delay");
  chk_pitch_step: assert property (clk_en && step && ball_seg != SEG_LAST
    |=> ball_seg == $past(ball_seg) + SEG_W'(1))
    else $error("pitch step did not advance ball");
  // same-cycle form: the ball legally jumps home on the edge that ends the delay
  chk_gate_closed: assert property (!pitch_gate_en && reset_delay |-> $stable(ball_seg))
    else $error("ball moved with pitch gate closed");
  chk_pitch_start: assert property ($past(s_r.phase) == PH_IDLE && s_r.phase == PH_PITCH
    |-> pitch_gate_en && ball_seg == '0)
    else $error("pitch started without gate");
  chk_return_pulse: assert property ($fell(reset_delay) && !game_over |-> ball_return)
    else $error("no return pulse after delay");
  chk_hit_cause: assert property (!hit_n |-> $past(coincide) && $past(ball_seg[SEG_W-1]))
    else $error("hit pulse without coincidence");
  chk_hit_score: assert property (!hit_n && first_batter
    |-> score_first == $past(score_first) + SCORE_W'($past(hit_value)))
    else $error("hit not added to first batter");
  chk_swing_open: assert property ($rose(swing_active) |-> bat_seg == '0 ##0 swing_active [*4])
    else $error("bat gate closed too early");
  chk_end_first: assert property ($rose(game_over) |-> $past(first_batter))
    else $error("game ended with second batter up");
  chk_coin_credit: assert property (clk_en && credit_inc && !credit_dec
    |=> credits == $past(credits) + CREDIT_W'(1))
    else $error("coin not credited");
endmodule // pitch_bat_game_sequencer

// File: verification/rc_partner.sv
module rc_partner (
  input  wire logic clk,        // master clock
  output logic      rx_n_pin,   // receiver line
  output logic      coin_n_pin  // coin contact
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    rx_n_pin   = 1'b1;
    coin_n_pin = 1'b1;
  end

  // low for n cycles, then idle n cycles so the release is seen too
  task automatic key(input int n);
    @(posedge clk);
    rx_n_pin <= 1'b0;
    repeat (n) @(posedge clk);
    rx_n_pin <= 1'b1;
    repeat (n) @(posedge clk);
  endtask

  task automatic coin(input int n);
    @(posedge clk);
    coin_n_pin <= 1'b0;
    repeat (n) @(posedge clk);
    coin_n_pin <= 1'b1;
    repeat (n) @(posedge clk);
  endtask
endmodule // rc_partner

// File: verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import game_seq_pkg::*;

  localparam int RD = 40;
  localparam int GO = 60;
  localparam int DB = 2;
  localparam int K  = DB + 3;

  logic                clk;
  logic                rst_n;
  logic                clk_en;
  logic                rx_n_pin;
  logic                coin_n_pin;
  logic [SEL_W-1:0]    score_sel;
  logic [HIT_W-1:0]    hit_value;
  logic [SEG_W-1:0]    ball_seg;
  logic [SEG_W-1:0]    bat_seg;
  logic                pitch_gate_en;
  logic                pitch_done;
  logic                swing_active;
  logic                reset_delay;
  logic                ball_return;
  logic                hit_n;
  logic                first_batter;
  logic [SCORE_W-1:0]  score_first;
  logic [SCORE_W-1:0]  score_second;
  logic                game_over;
  logic [CREDIT_W-1:0] credits;
  int                  n_errors;
  int                  n_checks;
  int                  cyc;
  int                  d_meas;
  int                  p_meas;

  rc_partner pm (.clk(clk), .rx_n_pin(rx_n_pin), .coin_n_pin(coin_n_pin));

  pitch_bat_game_sequencer #(.RD_CYC(RD), .GO_CYC(GO), .DB_CYC(DB)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .rx_n_pin(rx_n_pin),
    .coin_n_pin(coin_n_pin), .score_sel(score_sel), .hit_value(hit_value),
    .ball_seg(ball_seg), .bat_seg(bat_seg), .pitch_gate_en(pitch_gate_en),
    .pitch_done(pitch_done), .swing_active(swing_active),
    .reset_delay(reset_delay), .ball_return(ball_return), .hit_n(hit_n),
    .first_batter(first_batter), .score_first(score_first),
    .score_second(score_second), .game_over(game_over), .credits(credits));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a hang costs one mismatch and ends the run through the normal report
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one pitch with optional swing; hits and swing length are tallied on the way
  task automatic run_pitch(input bit swing, input int hits);
    int c0, s, st, lows, sw, rd, i;
    logic fb;
    logic [SCORE_W-1:0] sf, ss;
    logic [SEG_W-1:0] pb;
    c0 = cyc;
    s = -1;
    st = -1;
    lows = 0;
    sw = 0;
    rd = 0;
    fb = first_batter;
    sf = score_first;
    ss = score_second;
    pb = 4'h0;
    fork
      begin
        pm.key(K);
        if (swing)
          pm.key(K);
      end
    join_none
    for (i = 0; i < 600 && !(s >= 0 && pitch_done === 1'b1); i++)
    begin
      tick();
      if (s < 0 && pitch_gate_en === 1'b1)
      begin
        s = cyc;
        chk("ball_seg at start", 0, ball_seg);
      end
      if (s >= 0 && ball_seg !== pb)
      begin
        if (st >= 0)
          chk("step spacing", 16, cyc - st);
        st = cyc;
      end
      pb = ball_seg;
      if (hit_n === 1'b0)
      begin
        lows++;
        chk("ball_seg at hit", 1, ball_seg >= 4'h8);
      end
      if (swing_active === 1'b1)
        sw++;
      if (sw == 1 && swing_active === 1'b1)
        chk("bat_seg at swing start", 0, bat_seg);
    end
    d_meas = s - c0;
    p_meas = st % 16;
    chk("gate and complement", 2'b01, {pitch_gate_en, pitch_done});
    chk("reset_delay at pitch end", 1, reset_delay);
    chk("game_over in pitch", 0, game_over);
    pb = ball_seg;
    while (reset_delay === 1'b1 && rd < 200)
    begin
      if (ball_seg !== pb)
        chk("ball_seg frozen", pb, ball_seg);
      rd++;
      tick();
      if (swing_active === 1'b1)
        sw++;
    end
    chk("reset_delay length", RD, rd);
    chk("return pulse", 1, ball_return);
    chk("batter toggled", !fb, first_batter);
    chk("hit pulses", hits, lows);
    if (swing)
      chk("swing length", 256, sw);
    chk("first score", (fb && hits > 0) ? sf + hit_value : sf, score_first);
    chk("second score", (!fb && hits > 0) ? ss + hit_value : ss, score_second);
    tick();
    chk("return pulse ends", 0, ball_return);
  endtask

  // start the pitch just after a ball step so the swing can line up
  task automatic aligned_hit;
    while (((cyc + d_meas) % 16) != ((p_meas + 1) % 16))
      tick();
    run_pitch(1'b1, 1);
  endtask

  task automatic t_reset;
    chk("flags after reset", 6'b011100,
        {pitch_gate_en, pitch_done, hit_n, first_batter, reset_delay, game_over});
    chk("credits after reset", 0, credits);
    $display("test reset done");
  endtask

  task automatic t_coin;
    pm.key(K);
    repeat (6) tick();
    chk("pitch without credit", 0, pitch_gate_en);
    pm.coin(1);
    repeat (6) tick();
    chk("credits after bounce", 0, credits);
    pm.coin(K);
    repeat (6) tick();
    chk("credits after coin", 1, credits);
    // a coin while the enable is low must leave no trace, not even in the synchronisers
    @(posedge clk);
    clk_en <= 1'b0;
    pm.coin(K);
    tick();
    chk("credits while frozen", 1, credits);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (6) tick();
    chk("credits after freeze", 1, credits);
    $display("test coin done");
  endtask

  task automatic t_game;
    int n;
    run_pitch(1'b0, 0);
    aligned_hit();
    aligned_hit();
    aligned_hit();
    n = 0;
    while (game_over !== 1'b1 && n < 5)
    begin
      n++;
      tick();
    end
    chk("game_over start", 1, game_over);
    chk("credits used", 0, credits);
    n = 0;
    while (game_over === 1'b1 && n < 200)
    begin
      n++;
      tick();
    end
    chk("game_over length", GO, n);
    chk("scores cleared", 0, {score_first, score_second});
    chk("first batter up", 1, first_batter);
    $display("test game done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    score_sel = 3'h1;
    hit_value = 3'h5;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    t_reset();
    t_coin();
    t_game();
    conclude();
  end
endmodule // tb_top
